// ===== hw/twi_slave_unit.sv
// Two-wire slave unit with the flag and clock-hold quirks of this revision
// Operation
// - START clears transmit collision flag; repeated START leaves it alone.
// - Flag clear colliding with address set keeps SCL held until reset.
// - Timeout and START in same cycle drop the transaction.
// - Response command clears data flag one cycle later.
// - SDA hold selection is a single bit.
// - No second interface instance; its writes are ignored.
`timescale 1ns/1ps
module twi_slave_unit #(
  parameter int unsigned FIFO_DEPTH = twi_errata_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                               i_clock,
  input  wire logic                               i_reset,
  // Bus pins
  input  wire logic                               i_scl,
  input  wire logic                               i_sda,
  output logic                                    o_scl_oe,
  output logic                                    o_sda_oe,
  // Configuration
  input  wire logic [6:0]                         i_own_addr,
  input  wire logic                               i_timeout_en,
  input  wire logic                               i_sda_hold_select,
  // Software commands
  input  wire logic [2:0]                         i_flag_clear,
  input  wire logic                               i_cmd_valid,
  input  wire logic [1:0]                         i_cmd,
  input  wire logic                               i_nack,
  input  wire logic [twi_errata_pkg::DATA_W-1:0]  i_tx_byte,
  // Status
  output twi_errata_pkg::status_t                 o_status,
  // Received bytes
  output logic                                    o_rx_valid,
  output logic [twi_errata_pkg::DATA_W-1:0]       o_rx_data,
  input  wire logic                               i_rx_ready
);
  localparam int unsigned TW = $clog2(twi_errata_pkg::TIMEOUT_CYC + 1);
  initial begin
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH too small");
  end
  // one instance only, so no decode exists for a second one

  // ----------------------------------------------------------------
  // Pin synchronisers and line events
  // ----------------------------------------------------------------
  logic [2:0] scl_sync_ff, sda_sync_ff;
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], i_scl};
      sda_sync_ff <= {sda_sync_ff[1:0], i_sda};
    end
  end
  logic scl, sda, scl_rise, scl_fall, start_det, stop_det;
  assign scl       = scl_sync_ff[1];
  assign sda       = sda_sync_ff[1];
  assign scl_rise  = scl && !scl_sync_ff[2];
  assign scl_fall  = !scl && scl_sync_ff[2];
  assign start_det = scl && scl_sync_ff[2] && !sda && sda_sync_ff[2];
  assign stop_det  = scl && scl_sync_ff[2] && sda && !sda_sync_ff[2];

  // ----------------------------------------------------------------
  // Slave state
  // ----------------------------------------------------------------
  twi_errata_pkg::state_t  state_ff, nxt_state;
  twi_errata_pkg::status_t st_ff, nxt_st;
  logic [3:0]    cnt_ff, nxt_cnt;
  logic [7:0]    shift_ff, nxt_shift;
  logic [TW-1:0] tout_ff, nxt_tout;
  logic          clr_pend_ff, nxt_clr_pend;
  logic          sda_req_ff, nxt_sda_req;
  logic [1:0]    hold_cnt_ff, nxt_hold_cnt;
  logic          sda_oe_ff, nxt_sda_oe;
  logic          timeout_hit, addr_set, push_valid, push_ready, resp_cmd;

  assign timeout_hit = i_timeout_en && st_ff.bus_busy
                       && tout_ff == TW'(twi_errata_pkg::TIMEOUT_CYC);
  assign resp_cmd    = i_cmd_valid && i_cmd == twi_errata_pkg::CMD_RESPONSE;
  assign addr_set    = state_ff == twi_errata_pkg::S_ADDR && scl_fall
                       && cnt_ff == 4'h8 && shift_ff[7:1] == i_own_addr;
  assign push_valid  = state_ff == twi_errata_pkg::S_RX_PUSH;

  always_comb begin
    nxt_state    = state_ff;
    nxt_st       = st_ff;
    nxt_cnt      = cnt_ff;
    nxt_shift    = shift_ff;
    nxt_sda_req  = sda_req_ff;
    nxt_clr_pend = 1'b0;
    nxt_tout     = (scl_rise || scl_fall || !st_ff.bus_busy) ? '0 : tout_ff + 1'b1;
    // Write-one clears; sets below override them
    if (i_flag_clear[twi_errata_pkg::CLR_ADDR_STOP]) nxt_st.addr_stop_int_flag = 1'b0;
    if (i_flag_clear[twi_errata_pkg::CLR_DATA])      nxt_st.data_int_flag = 1'b0;
    if (i_flag_clear[twi_errata_pkg::CLR_TXCOL])     nxt_st.tx_collision = 1'b0;
    // Response clears the data flag a cycle late
    if (resp_cmd) nxt_clr_pend = 1'b1;
    if (clr_pend_ff) nxt_st.data_int_flag = 1'b0;
    if (scl_rise) begin
      nxt_shift = {shift_ff[6:0], sda};
      nxt_cnt   = cnt_ff + 4'h1;
    end
    // SDA settles before SCL goes, else the line change reads as START or STOP
    if (st_ff.scl_stretch_hold && sda_oe_ff == sda_req_ff && hold_cnt_ff == 2'h0
        && (state_ff == twi_errata_pkg::S_ADDR_ACK || state_ff == twi_errata_pkg::S_RX_ACK
            || state_ff == twi_errata_pkg::S_TX || state_ff == twi_errata_pkg::S_SKIP)) begin
      nxt_st.scl_stretch_hold = 1'b0;
    end
    unique case (state_ff)
      twi_errata_pkg::S_IDLE, twi_errata_pkg::S_SKIP: begin
      end
      twi_errata_pkg::S_ADDR: begin
        if (scl_fall && cnt_ff == 4'h8) begin
          if (addr_set) begin
            nxt_st.addr_stop_int_flag = 1'b1;
            nxt_st.scl_stretch_hold   = 1'b1;
            nxt_st.read_dir           = shift_ff[0];
            nxt_state                 = twi_errata_pkg::S_ADDR_WAIT;
            // Clear landing on the set cycle loses the hold release
            if (i_flag_clear[twi_errata_pkg::CLR_ADDR_STOP]) nxt_st.bus_locked = 1'b1;
          end else begin
            nxt_state = twi_errata_pkg::S_SKIP;
          end
        end
      end
      twi_errata_pkg::S_ADDR_WAIT: begin
        if (!st_ff.addr_stop_int_flag && !st_ff.bus_locked) begin
          nxt_sda_req             = 1'b1;
          nxt_state               = twi_errata_pkg::S_ADDR_ACK;
        end
      end
      twi_errata_pkg::S_ADDR_ACK, twi_errata_pkg::S_RX_ACK: begin
        if (scl_fall) begin
          nxt_cnt = 4'h0;
          if (st_ff.read_dir) begin
            nxt_st.data_int_flag    = 1'b1;
            nxt_st.scl_stretch_hold = 1'b1;
            nxt_state               = twi_errata_pkg::S_DATA_WAIT;
          end else begin
            nxt_sda_req = 1'b0;
            nxt_state   = twi_errata_pkg::S_RX;
          end
        end
      end
      twi_errata_pkg::S_RX: begin
        if (scl_fall && cnt_ff == 4'h8) begin
          nxt_st.scl_stretch_hold = 1'b1;
          nxt_state               = twi_errata_pkg::S_RX_PUSH;
        end
      end
      twi_errata_pkg::S_RX_PUSH: begin
        // A full FIFO keeps SCL stretched until the drain side catches up
        if (push_ready) begin
          nxt_st.data_int_flag = 1'b1;
          nxt_state            = twi_errata_pkg::S_DATA_WAIT;
        end
      end
      twi_errata_pkg::S_DATA_WAIT: begin
        if (i_cmd_valid && i_cmd == twi_errata_pkg::CMD_COMPLETE) begin
          nxt_sda_req             = 1'b0;
          nxt_state               = twi_errata_pkg::S_SKIP;
        end else if (resp_cmd) begin
          nxt_cnt                 = 4'h0;
          if (st_ff.read_dir) begin
            nxt_shift   = i_tx_byte;
            nxt_sda_req = !i_tx_byte[7];
            nxt_state   = twi_errata_pkg::S_TX;
          end else begin
            nxt_sda_req = !i_nack;
            nxt_state   = twi_errata_pkg::S_RX_ACK;
          end
        end
      end
      twi_errata_pkg::S_TX: begin
        if (scl_rise) begin
          nxt_shift = {shift_ff[6:0], 1'b0};
          if (!sda_req_ff && !sda) nxt_st.tx_collision = 1'b1;
        end
        if (scl_fall) begin
          nxt_sda_req = cnt_ff == 4'h8 ? 1'b0 : !shift_ff[7];
          if (cnt_ff == 4'h8) nxt_state = twi_errata_pkg::S_TX_ACK;
        end
      end
      twi_errata_pkg::S_TX_ACK: begin
        if (scl_rise) nxt_state = sda ? twi_errata_pkg::S_SKIP : twi_errata_pkg::S_TX_GO;
      end
      twi_errata_pkg::S_TX_GO: begin
        if (scl_fall) begin
          nxt_st.data_int_flag    = 1'b1;
          nxt_st.scl_stretch_hold = 1'b1;
          nxt_state               = twi_errata_pkg::S_DATA_WAIT;
        end
      end
    endcase
    if (stop_det) begin
      if (state_ff != twi_errata_pkg::S_IDLE && state_ff != twi_errata_pkg::S_SKIP) begin
        nxt_st.addr_stop_int_flag = 1'b1;
      end
      nxt_st.bus_busy = 1'b0;
      nxt_sda_req     = 1'b0;
      nxt_state       = twi_errata_pkg::S_IDLE;
    end
    if (start_det) begin
      if (!st_ff.bus_busy) nxt_st.tx_collision = 1'b0;
      nxt_st.bus_busy = 1'b1;
      nxt_sda_req     = 1'b0;
      nxt_cnt         = 4'h0;
      nxt_state       = twi_errata_pkg::S_ADDR;
    end
    if (timeout_hit) begin
      // Coincident START is dropped with the timed-out transfer
      nxt_st.bus_busy         = 1'b0;
      nxt_st.scl_stretch_hold = st_ff.bus_locked;
      nxt_sda_req             = 1'b0;
      nxt_state               = twi_errata_pkg::S_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // SDA hold delay after SCL falls
  // ----------------------------------------------------------------
  always_comb begin
    nxt_sda_oe   = sda_oe_ff;
    nxt_hold_cnt = hold_cnt_ff;
    if (scl_fall) begin
      nxt_hold_cnt = i_sda_hold_select ? 2'(twi_errata_pkg::SDA_HOLD_CYC) : 2'h0;
    end else if (hold_cnt_ff != 2'h0) begin
      nxt_hold_cnt = hold_cnt_ff - 2'h1;
    end else begin
      nxt_sda_oe = sda_req_ff;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_ff    <= twi_errata_pkg::S_IDLE;
      st_ff       <= twi_errata_pkg::STATUS_RESET;
      cnt_ff      <= '0;
      shift_ff    <= '0;
      tout_ff     <= '0;
      clr_pend_ff <= 1'b0;
      sda_req_ff  <= 1'b0;
      hold_cnt_ff <= '0;
      sda_oe_ff   <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      st_ff       <= nxt_st;
      cnt_ff      <= nxt_cnt;
      shift_ff    <= nxt_shift;
      tout_ff     <= nxt_tout;
      clr_pend_ff <= nxt_clr_pend;
      sda_req_ff  <= nxt_sda_req;
      hold_cnt_ff <= nxt_hold_cnt;
      sda_oe_ff   <= nxt_sda_oe;
    end
  end
  assign o_status = st_ff;
  assign o_scl_oe = st_ff.scl_stretch_hold;
  assign o_sda_oe = sda_oe_ff;

  rx_fifo #(.WIDTH(twi_errata_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .i_clock     (i_clock),
    .i_reset     (i_reset),
    .i_in_valid  (push_valid),
    .i_in_data   (shift_ff),
    .o_in_ready  (push_ready),
    .o_out_valid (o_rx_valid),
    .o_out_data  (o_rx_data),
    .i_out_ready (i_rx_ready)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  sequence resp_then_late_clear;
    st_ff.data_int_flag ##1 !st_ff.data_int_flag;
  endsequence
  a_start_clears_col: assert property (
    start_det && !st_ff.bus_busy && !timeout_hit |=> !st_ff.tx_collision)
    else $error("start kept collision");
  a_rstart_keeps_col: assert property (
    start_det && st_ff.bus_busy && st_ff.tx_collision
    && !i_flag_clear[twi_errata_pkg::CLR_TXCOL] |=> st_ff.tx_collision)
    else $error("repeated start cleared collision");
  a_collide_locks_scl: assert property (
    addr_set && i_flag_clear[twi_errata_pkg::CLR_ADDR_STOP]
    |=> st_ff.bus_locked ##1 o_scl_oe [*3])
    else $error("colliding clear released hold");
  a_timeout_drops_start: assert property (
    timeout_hit && start_det |=> state_ff == twi_errata_pkg::S_IDLE && !st_ff.bus_busy)
    else $error("start kept at timeout");
  a_data_late_clear: assert property (
    resp_cmd && st_ff.data_int_flag && i_flag_clear == 3'h0 |=> resp_then_late_clear)
    else $error("data flag clear not one cycle late");
  a_zero_keeps_flags: assert property (
    st_ff.addr_stop_int_flag && !i_flag_clear[twi_errata_pkg::CLR_ADDR_STOP]
    |=> st_ff.addr_stop_int_flag)
    else $error("flag lost without clear");
  a_match_sets_hold: assert property (
    addr_set |=> st_ff.addr_stop_int_flag && o_scl_oe)
    else $error("match did not hold SCL");
  a_hold_till_clear: assert property (
    state_ff == twi_errata_pkg::S_ADDR_WAIT && st_ff.addr_stop_int_flag |-> o_scl_oe)
    else $error("SCL released before flag clear");
  a_sda_before_scl: assert property (
    $fell(o_scl_oe) && state_ff != twi_errata_pkg::S_IDLE |-> sda_oe_ff == sda_req_ff)
    else $error("SCL released before SDA settled");
  a_hold_bit_delay: assert property (
    scl_fall && i_sda_hold_select |=> $stable(sda_oe_ff) [*4])
    else $error("SDA moved inside hold time");
endmodule

// ===== hw/twi_errata_pkg.sv
// Shared constants and types for the two-wire slave unit
package twi_errata_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned TIMEOUT_US   = 100;
  localparam int unsigned TIMEOUT_CYC  = (CLK_HZ / 1_000_000) * TIMEOUT_US;
  localparam int unsigned SDA_HOLD_NS  = 300;
  localparam int unsigned SDA_HOLD_CYC = (SDA_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // ----------------------------------------------------------------
  // Commands, sizes, flag clear bit positions
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_RESPONSE = 2'h3;
  localparam logic [1:0] CMD_COMPLETE = 2'h2;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned FIFO_DEPTH  = 8;
  localparam int unsigned CLR_ADDR_STOP = 2;
  localparam int unsigned CLR_DATA      = 1;
  localparam int unsigned CLR_TXCOL     = 0;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic addr_stop_int_flag;
    logic data_int_flag;
    logic tx_collision;
    logic bus_busy;
    logic scl_stretch_hold;
    logic read_dir;
    logic bus_locked;
  } status_t;
  localparam status_t STATUS_RESET = '0;
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_WAIT, S_ADDR_ACK, S_RX, S_RX_PUSH, S_DATA_WAIT,
    S_RX_ACK, S_TX, S_TX_ACK, S_TX_GO, S_SKIP
  } state_t;
endpackage

// ===== hw/rx_fifo.sv
// Synchronous valid/ready FIFO for received bytes
`timescale 1ns/1ps
module rx_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic             push, pop;
  always_comb begin
    o_in_ready  = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
    o_out_valid = wr_ff != rd_ff;
    o_out_data  = mem_ff[rd_ff[AW-1:0]];
    push        = i_in_valid && o_in_ready;
    pop         = o_out_valid && i_out_ready;
    nxt_wr      = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd      = pop ? rd_ff + 1'b1 : rd_ff;
  end
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
    if (push) mem_ff[wr_ff[AW-1:0]] <= i_in_data;
  end
endmodule

// ===== tb/twi_master_model.sv
// Behavioural two-wire bus master driving open-drain pull-downs
`timescale 1ns/1ps
module twi_master_model (
  // Clock
  input  wire logic i_clock,
  // Bus levels and pull-downs
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_low,
  output logic      o_sda_low
);
  int stuck = 0;
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  // ----------------------------------------------------------------
  // Bus conditions, 800 ns bit period: 6 cycles low, 2 high
  // ----------------------------------------------------------------
  task automatic rise_scl();
    int k;
    k = 0;
    o_scl_low <= 1'b0;
    @(posedge i_clock);
    // Slave may stretch; give up so a locked bus cannot hang the run
    while (i_scl !== 1'b1 && k < 2000) begin
      @(posedge i_clock);
      k++;
    end
    if (k >= 2000) stuck++;
    @(posedge i_clock);
  endtask
  task automatic bit_io(input logic b, output logic seen);
    @(posedge i_clock);
    o_sda_low <= ~b;
    repeat (5) @(posedge i_clock);
    rise_scl();
    seen = i_sda;
    o_scl_low <= 1'b1;
  endtask
  task automatic xfer(input logic [7:0] b, output logic [7:0] got, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(b[i], got[i]);
    bit_io(1'b1, ack);
  endtask
  task automatic start_cond(input logic rep, input int gap);
    @(posedge i_clock);
    if (rep) begin
      o_sda_low <= 1'b0;
      repeat (3) @(posedge i_clock);
      rise_scl();
      repeat (gap) @(posedge i_clock);
    end
    o_sda_low <= 1'b1;
    repeat (4) @(posedge i_clock);
    o_scl_low <= 1'b1;
  endtask
  task automatic stop_cond();
    @(posedge i_clock);
    o_sda_low <= 1'b1;
    repeat (3) @(posedge i_clock);
    rise_scl();
    o_sda_low <= 1'b0;
    repeat (4) @(posedge i_clock);
  endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the two-wire slave unit against a bus master model
`timescale 1ns/1ps
module tb;
  logic                    clock, reset, timeout_en, cmd_valid, nack, rx_ready, ack, found;
  logic                    m_scl_low, m_sda_low, scl_oe, sda_oe, rx_valid, hold_sel;
  logic [2:0]              flag_clear;
  logic [1:0]              cmd;
  logic [6:0]              own;
  logic [7:0]              tx_byte, rx_data, got, tx;
  logic [15:0]             lfsr = 16'hB1E3;
  logic [7:0]              rxq[$];
  int                      bad_count = 0;
  int                      tests_run = 0;
  int                      hits = 0;
  twi_errata_pkg::status_t st;
  // Pull-ups: a released line reads high
  wire                     scl = ~(m_scl_low | scl_oe);
  wire                     sda = ~(m_sda_low | sda_oe);
  twi_slave_unit uut (.i_clock(clock), .i_reset(reset), .i_scl(scl), .i_sda(sda),
    .o_scl_oe(scl_oe), .o_sda_oe(sda_oe), .i_own_addr(own), .i_timeout_en(timeout_en),
    .i_sda_hold_select(hold_sel), .i_flag_clear(flag_clear), .i_cmd_valid(cmd_valid),
    .i_cmd(cmd), .i_nack(nack), .i_tx_byte(tx_byte), .o_status(st),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready));
  twi_master_model master (.i_clock(clock), .i_scl(scl), .i_sda(sda),
    .o_scl_low(m_scl_low), .o_sda_low(m_sda_low));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk_bit(input string what, input logic exp, input logic seen);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic pulse_clear(input logic [2:0] v);
    @(posedge clock);
    flag_clear <= v;
    @(posedge clock);
    flag_clear <= 3'h0;
    @(posedge clock);
    @(negedge clock);
  endtask
  task automatic wait_flag(input int n, input logic data, output logic seen);
    seen = 1'b0;
    for (int k = 0; k < n && !seen; k++) begin
      @(negedge clock);
      seen = (data ? st.data_int_flag : st.addr_stop_int_flag) === 1'b1;
    end
  endtask
  task automatic sw_addr(output logic f);
    wait_flag(300, 1'b0, f);
    if (f) begin
      chk_bit("hold on match", 1'b1, st.scl_stretch_hold);
      chk_bit("scl low at clear", 1'b0, scl);
      pulse_clear(3'h3);
      chk_bit("flag kept on zero", 1'b1, st.addr_stop_int_flag);
      pulse_clear(3'h5);
      chk_bit("flag cleared", 1'b0, st.addr_stop_int_flag);
      // Hold drops only once the ACK already stands on SDA
      repeat (2) @(negedge clock);
      chk_bit("scl released", 1'b0, scl_oe);
    end
  endtask
  task automatic sw_data(input logic n, input logic [7:0] t);
    logic f;
    wait_flag(300, 1'b1, f);
    chk_bit("data flag", 1'b1, f);
    chk_bit("hold on data", 1'b1, scl_oe);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd <= twi_errata_pkg::CMD_RESPONSE;
    nack <= n;
    tx_byte <= t;
    @(posedge clock);
    cmd_valid <= 1'b0;
    @(negedge clock);
    chk_bit("data flag still set", 1'b1, st.data_int_flag);
    @(negedge clock);
    chk_bit("data flag cleared", 1'b0, st.data_int_flag);
  endtask
  task automatic drain();
    @(posedge clock);
    rx_ready <= 1'b1;
    for (int k = 0; k < 200 && rxq.size() > 0; k++) begin
      @(posedge clock);
      if (rx_valid === 1'b1) chk_byte("rx byte", rxq.pop_front(), rx_data);
    end
    rx_ready <= 1'b0;
  endtask
  task automatic stop_clear(output logic f);
    master.stop_cond();
    wait_flag(50, 1'b0, f);
    if (f) pulse_clear(3'h4);
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (40000) @(posedge clock);
    bad_count++;
    close_out();
  end
  initial begin
    {reset, timeout_en, cmd_valid, nack, rx_ready, hold_sel} = 6'h20;
    {flag_clear, cmd, own, tx_byte} = '0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    lfsr = next_rand(lfsr);
    own <= {1'b1, lfsr[5:0]};
    @(negedge clock);
    chk_byte("status at reset", {1'b0, twi_errata_pkg::STATUS_RESET}, {1'b0, st});
    master.start_cond(1'b0, 0);
    fork
      master.xfer({own, 1'b0}, got, ack);
      sw_addr(found);
    join
    chk_bit("address acked", 1'b0, ack);
    // Ninth byte finds the buffer full while the reader stalls
    for (int i = 0; i < 9; i++) begin
      lfsr = next_rand(lfsr);
      rxq.push_back(lfsr[7:0]);
      fork
        master.xfer(lfsr[7:0], got, ack);
        if (i == 8) begin
          repeat (110) @(negedge clock);
          chk_bit("full buffer holds scl", 1'b1, scl_oe);
          chk_bit("no flag while full", 1'b0, st.data_int_flag);
          drain();
          sw_data(1'b0, 8'h00);
        end else sw_data(1'b0, 8'h00);
      join
      chk_bit("byte acked", 1'b0, ack);
    end
    stop_clear(found);
    chk_bit("stop flag", 1'b1, found);
    chk_bit("buffer empty", 1'b0, rx_valid);
    // Read with a forced collision on the last bit, then a repeated start
    lfsr = next_rand(lfsr);
    tx = lfsr[7:0] | 8'h01;
    master.start_cond(1'b0, 0);
    fork
      begin
        master.xfer({own, 1'b1}, got, ack);
        master.xfer(8'hFE, got, ack);
      end
      begin
        sw_addr(found);
        sw_data(1'b0, tx);
      end
    join
    chk_byte("read byte", tx & 8'hFE, got);
    chk_bit("collision set", 1'b1, st.tx_collision);
    master.start_cond(1'b1, 0);
    @(negedge clock);
    chk_bit("collision on repeat", 1'b1, st.tx_collision);
    // Hold option on transfers the unit only watches
    @(posedge clock);
    hold_sel <= 1'b1;
    master.xfer({own ^ 7'h01, 1'b0}, got, ack);
    chk_bit("other address ignored", 1'b1, ack);
    stop_clear(found);
    chk_bit("no flag unaddressed", 1'b0, found);
    master.start_cond(1'b0, 0);
    @(negedge clock);
    chk_bit("collision on start", 1'b0, st.tx_collision);
    master.xfer({own ^ 7'h01, 1'b0}, got, ack);
    stop_clear(found);
    // Starts up to the timeout instant are lost; later ones meet an idle bus
    @(posedge clock);
    timeout_en <= 1'b1;
    hold_sel   <= 1'b0;
    for (int d = 996; d < 1005; d++) begin
      master.start_cond(1'b0, 0);
      master.xfer({own ^ 7'h01, 1'b0}, got, ack);
      master.start_cond(1'b1, d);
      fork
        master.xfer({own, 1'b0}, got, ack);
        sw_addr(found);
      join
      hits += int'(found);
      chk_bit("start kept", d >= 1000, found);
      stop_clear(found);
    end
    chk_byte("dropped starts", 8'h04, 8'(9 - hits));
    @(posedge clock);
    timeout_en <= 1'b0;
    // Clear held across the match sets both at once
    master.start_cond(1'b0, 0);
    flag_clear <= 3'h4;
    fork
      master.xfer({own, 1'b0}, got, ack);
      begin
        repeat (120) @(posedge clock);
        flag_clear <= 3'h0;
      end
    join
    @(negedge clock);
    chk_bit("bus locked", 1'b1, st.bus_locked);
    chk_bit("scl never released", 1'b1, scl_oe);
    chk_bit("master stalled", 1'b1, master.stuck == 1);
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    chk_byte("status after reset", {1'b0, twi_errata_pkg::STATUS_RESET}, {1'b0, st});
    chk_bit("scl freed by reset", 1'b0, scl_oe);
    close_out();
  end
endmodule
